//--- pic_ctrl.sv
// What this block does
// - 36 channels: flag, level, DMA vector link
// - Flag holds peripheral request until cleared
// - Clear on reset, vector read, clear write
// - Clear on DMA accept and burst end
// - Per-source writable level, zero to seven
// - Level zero or seven never forwarded unless routed to DMA
// - Watchdog request always at level seven
// - Equal maskable levels: lowest vector wins
// - Bits three and seven show flags
// - Present only best request, level, vector
// - CPU accepts only level above mask
// - CPU mask becomes accepted level plus one, max seven; DMA accept leaves it
// - Nested requests above mask accepted
// - Return restores saved mask
// - Four start vectors route sources to DMA
// - Software sets DMA parameters before enabling
// - DMA requests raised at level six
// - Several DMA requests: lowest channel first
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.svh"
module pic_ctrl #(
  parameter int NCH  = 36,  // Number of maskable channels
  parameter int NDMA = 4    // Number of DMA start vectors
) (
  input  wire logic           mclk,     // System clock
  input  wire logic           resetn,   // Asynchronous reset, low
  input  wire logic [NCH-1:0] src_req,  // Peripheral request pulses
  input  wire logic           wdt_req,  // Watchdog request pulse
  pic_if.dev                  bus       // Link to the CPU end
);
  import pic_pkg::*;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [NCH-1:0] flag_q;           // Request flags
  pic_lvl_t       lvl_q [NCH];      // Programmed levels
  pic_vec_t       dvec_q [NDMA];    // DMA start vectors
  logic           wdt_q;            // Watchdog flag
  logic [NCH-1:0] clr;              // Clear strobes this cycle
  logic [NCH-1:0] routed;           // Channel named by a start vector
  logic [NDMA-1:0] dpend;           // DMA channel has a pending source
  logic           wdt_clr;          // Watchdog flag read by CPU

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Channel number to vector
  function automatic pic_vec_t ch2vec(input int ch);
    return pic_vec_t'(ch + 1);
  endfunction

  // Vector names a maskable channel
  function automatic logic vec_ok(input pic_vec_t v);
    return (v != `PIC_VEC_NONE) && (int'(v) <= NCH);
  endfunction

  // Address hits priority register, returns its index
  function automatic logic pri_hit(input pic_byte_t a, output int idx);
    idx = int'(a) - int'(`PIC_PRI_BASE);
    return (a >= `PIC_PRI_BASE) && (idx < NCH / 2);
  endfunction

  // --------------------------------------------------------------------
  // Clear events and DMA routing
  // --------------------------------------------------------------------
  // Gathers every clear source for each flag
  always_comb begin
    clr     = '0;
    routed  = '0;
    dpend   = '0;
    wdt_clr = bus.int_ack && (bus.ack_vec == `PIC_VEC_NMI);
    for (int i = 0; i < NCH; i++) begin
      // Vector read after accept, normal or DMA
      if (bus.int_ack && bus.ack_vec == ch2vec(i)) begin
        clr[i] = 1'b1;
      end
      // Software clear by writing the vector
      if (bus.reg_wr && bus.reg_addr == `PIC_CLR_ADDR &&
          bus.reg_wdata[5:0] == ch2vec(i)) begin
        clr[i] = 1'b1;
      end
    end
    for (int n = 0; n < NDMA; n++) begin
      if (vec_ok(dvec_q[n])) begin
        routed[int'(dvec_q[n]) - 1] = 1'b1;
        dpend[n] = flag_q[int'(dvec_q[n]) - 1];
        // Burst end clears the flag of its source
        if (bus.dma_done && bus.done_dch == pic_dch_t'(n)) begin
          clr[int'(dvec_q[n]) - 1] = 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Request flags
  // --------------------------------------------------------------------
  // A new request wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | src_req;
    end
  end

  // Watchdog flag, same discipline
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdt_q <= 1'b0;
    end else begin
      wdt_q <= (wdt_q && !wdt_clr) || wdt_req;
    end
  end

  // --------------------------------------------------------------------
  // Level and start vector registers
  // --------------------------------------------------------------------
  // Two levels per priority register, even channel low nibble
  always_ff @(posedge mclk or negedge resetn) begin
    int idx;
    idx = 0;
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        lvl_q[i] <= `PIC_LVL_RST;
      end
    end else if (bus.reg_wr && pri_hit(bus.reg_addr, idx)) begin
      lvl_q[2*idx]   <= bus.reg_wdata[`PIC_LO_LVL];
      lvl_q[2*idx+1] <= bus.reg_wdata[`PIC_HI_LVL];
    end
  end

  // Start vectors; a burst end empties its register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NDMA; n++) begin
        dvec_q[n] <= `PIC_VEC_NONE;
      end
    end else begin
      for (int n = 0; n < NDMA; n++) begin
        if (bus.reg_wr &&
            bus.reg_addr == `PIC_DVEC_BASE + pic_byte_t'(n)) begin
          dvec_q[n] <= bus.reg_wdata[5:0];
        end else if (bus.dma_done && bus.done_dch == pic_dch_t'(n)) begin
          dvec_q[n] <= `PIC_VEC_NONE;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------
  // Read data lands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge resetn) begin
    int idx;
    idx = 0;
    if (!resetn) begin
      bus.reg_rdata <= '0;
    end else if (bus.reg_rd) begin
      bus.reg_rdata <= '0;
      if (pri_hit(bus.reg_addr, idx)) begin
        bus.reg_rdata <= {flag_q[2*idx+1], lvl_q[2*idx+1],
                          flag_q[2*idx], lvl_q[2*idx]};
      end else if (bus.reg_addr >= `PIC_DVEC_BASE &&
                   bus.reg_addr < `PIC_DVEC_BASE + pic_byte_t'(NDMA)) begin
        bus.reg_rdata <= {2'h0,
          dvec_q[int'(bus.reg_addr - `PIC_DVEC_BASE)]};
      end
    end
  end

  // --------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------
  pic_lvl_t best_lvl; // Best maskable level, zero if none
  int       best_ch;  // Its channel
  logic     dma_any;  // Some DMA channel pending
  int       dma_n;    // Lowest pending DMA channel
  int       dma_ch;   // Its source channel
  logic     take_dma; // DMA request beats the maskable one

  // Picks the best maskable and the best DMA request
  always_comb begin
    best_lvl = `PIC_LVL_OFF;
    best_ch  = 0;
    dma_any  = 1'b0;
    dma_n    = 0;
    dma_ch   = 0;
    for (int i = 0; i < NCH; i++) begin
      // Levels 0 and 7 never compete; strict compare keeps low vector
      if (flag_q[i] && !routed[i] && lvl_q[i] != `PIC_LVL_OFF &&
          lvl_q[i] != `PIC_LVL_DIS7 && lvl_q[i] > best_lvl) begin
        best_lvl = lvl_q[i];
        best_ch  = i;
      end
    end
    for (int n = NDMA - 1; n >= 0; n--) begin
      if (dpend[n]) begin
        dma_any = 1'b1;
        dma_n   = n;
        dma_ch  = int'(dvec_q[n]) - 1;
      end
    end
    // DMA sits at level six; a level-six tie goes to the lower vector
    take_dma = dma_any && (best_lvl < `PIC_LVL_DMA || dma_ch < best_ch);
  end

  // --------------------------------------------------------------------
  // Presented request
  // --------------------------------------------------------------------
  // Refreshed every cycle from the current flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.int_req   <= 1'b0;
      bus.int_level <= `PIC_LVL_OFF;
      bus.int_vec   <= `PIC_VEC_NONE;
      bus.int_dma   <= 1'b0;
      bus.int_dch   <= '0;
    end else if (wdt_q) begin
      bus.int_req   <= 1'b1;
      bus.int_level <= `PIC_LVL_NMI;
      bus.int_vec   <= `PIC_VEC_NMI;
      bus.int_dma   <= 1'b0;
      bus.int_dch   <= '0;
    end else if (take_dma) begin
      bus.int_req   <= 1'b1;
      bus.int_level <= `PIC_LVL_DMA;
      bus.int_vec   <= ch2vec(dma_ch);
      bus.int_dma   <= 1'b1;
      bus.int_dch   <= pic_dch_t'(dma_n);
    end else begin
      bus.int_req   <= (best_lvl != `PIC_LVL_OFF);
      bus.int_level <= best_lvl;
      bus.int_vec   <= ch2vec(best_ch);
      bus.int_dma   <= 1'b0;
      bus.int_dch   <= '0;
    end
  end
endmodule
`default_nettype wire

//--- pic_defines.svh
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PIC_DVEC_BASE   8'h80   // Four DMA start vector registers
`define PIC_CLR_ADDR    8'h88   // Flag clear register, write a vector
`define PIC_PRI_BASE    8'h90   // First priority register (ch 0 and 1)

// ----------------------------------------------------------------------
// Priority register fields
// ----------------------------------------------------------------------
`define PIC_LO_LVL      2:0     // Level of even channel
`define PIC_LO_FLAG     3       // Request flag of even channel
`define PIC_HI_LVL      6:4     // Level of odd channel
`define PIC_HI_FLAG     7       // Request flag of odd channel

// ----------------------------------------------------------------------
// Levels, vectors and reset values
// ----------------------------------------------------------------------
`define PIC_LVL_OFF     3'h0    // Disabled level
`define PIC_LVL_DIS7    3'h7    // Also disabled for maskable sources
`define PIC_LVL_DMA     3'h6    // Level of a DMA routed request
`define PIC_LVL_NMI     3'h7    // Fixed watchdog level
`define PIC_VEC_NONE    6'h00   // Empty start vector
`define PIC_VEC_NMI     6'h3f   // Watchdog vector
`define PIC_LVL_RST     3'h0    // Level after reset
`define PIC_MASK_RST    3'h7    // CPU mask after reset
`define PIC_ACK_GAP     2'h2    // Cycles the CPU waits after an accept

`endif

//--- pic_pkg.sv
package pic_pkg;
  typedef logic [2:0] pic_lvl_t;  // Priority level
  typedef logic [5:0] pic_vec_t;  // Vector, channel plus one
  typedef logic [1:0] pic_dch_t;  // DMA channel number
  typedef logic [7:0] pic_byte_t; // Register byte
endpackage

//--- pic_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pic_if;
  import pic_pkg::*;
  logic      int_req;   // Request presented to the CPU
  pic_lvl_t  int_level; // Its level
  pic_vec_t  int_vec;   // Its vector
  logic      int_dma;   // Request is routed to DMA
  pic_dch_t  int_dch;   // DMA channel of the request
  logic      int_ack;   // CPU reads the vector, one cycle
  pic_vec_t  ack_vec;   // Vector being read
  logic      dma_done;  // DMA burst ended, one cycle
  pic_dch_t  done_dch;  // Channel that ended
  logic      reg_wr;    // Register write strobe
  logic      reg_rd;    // Register read strobe
  pic_byte_t reg_addr;  // Register address
  pic_byte_t reg_wdata; // Write data
  pic_byte_t reg_rdata; // Read data, one cycle after reg_rd
  modport dev (output int_req, int_level, int_vec, int_dma, int_dch,
               reg_rdata,
               input int_ack, ack_vec, dma_done, done_dch, reg_wr,
               reg_rd, reg_addr, reg_wdata);
  modport cpu (input int_req, int_level, int_vec, int_dma, int_dch,
               reg_rdata,
               output int_ack, ack_vec, dma_done, done_dch, reg_wr,
               reg_rd, reg_addr, reg_wdata);
endinterface
`default_nettype wire

//--- pic_cpu.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.svh"
module pic_cpu #(
  parameter int DEPTH = 8  // Nesting depth of the saved mask stack
) (
  input  wire logic             mclk,       // System clock
  input  wire logic             resetn,     // Asynchronous reset, low
  input  wire logic             return_from_interrupt,       // Return from interrupt pulse
  input  wire logic             mask_ld,    // Load a new mask, pulse
  input  wire pic_pkg::pic_lvl_t mask_new,  // Mask value to load
  input  wire logic             burst_end,  // DMA burst finished pulse
  input  wire pic_pkg::pic_dch_t burst_dch, // Channel that finished
  input  wire logic             wr,         // Register write request
  input  wire logic             rd,         // Register read request
  input  wire pic_pkg::pic_byte_t addr,     // Register address
  input  wire pic_pkg::pic_byte_t wdata,    // Write data
  output var  pic_pkg::pic_byte_t rdata,    // Read data
  output var  pic_pkg::pic_lvl_t  mask,     // Current interrupt mask
  output var  logic             irq_taken,  // Interrupt accepted pulse
  output var  logic             dma_taken,  // DMA request accepted pulse
  output var  pic_pkg::pic_vec_t  taken_vec, // Accepted vector
  output var  pic_pkg::pic_dch_t  taken_dch, // Accepted DMA channel
  pic_if.cpu                    bus         // Link to the controller
);
  import pic_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  pic_lvl_t mask_q;              // Interrupt mask level
  pic_lvl_t stk_q [DEPTH];       // Saved masks
  int       sp_q;                // Stack depth in use
  logic [1:0] gap_q;             // Hold-off after an accept
  logic     accept;              // Take the presented request

  // Accept only above the mask, and not while a clear is in flight
  assign accept = bus.int_req && bus.int_level > mask_q &&
                  gap_q == 2'h0;

  // --------------------------------------------------------------------
  // Mask and stack
  // --------------------------------------------------------------------
  // Normal accepts push and raise; a return pops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= `PIC_MASK_RST;
      sp_q   <= 0;
      for (int i = 0; i < DEPTH; i++) begin
        stk_q[i] <= `PIC_MASK_RST;
      end
    end else if (accept && !bus.int_dma && sp_q < DEPTH) begin
      stk_q[sp_q] <= mask_q;
      sp_q        <= sp_q + 1;
      // Saturate at seven so a watchdog accept stays masked
      mask_q <= (bus.int_level == `PIC_LVL_NMI) ? `PIC_LVL_NMI :
                pic_lvl_t'(bus.int_level + 3'h1);
    end else if (return_from_interrupt && sp_q > 0) begin
      mask_q <= stk_q[sp_q - 1];
      sp_q   <= sp_q - 1;
    end else if (mask_ld) begin
      // Software opens or closes the mask; without it nothing is taken
      mask_q <= mask_new;
    end
  end

  // --------------------------------------------------------------------
  // Accept handshake
  // --------------------------------------------------------------------
  // Vector read pulse and hold-off counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.int_ack <= 1'b0;
      bus.ack_vec <= `PIC_VEC_NONE;
      gap_q       <= 2'h0;
      irq_taken   <= 1'b0;
      dma_taken   <= 1'b0;
      taken_vec   <= `PIC_VEC_NONE;
      taken_dch   <= '0;
    end else begin
      bus.int_ack <= accept;
      irq_taken   <= accept && !bus.int_dma;
      dma_taken   <= accept && bus.int_dma;
      if (accept) begin
        bus.ack_vec <= bus.int_vec;
        taken_vec   <= bus.int_vec;
        taken_dch   <= bus.int_dch;
        gap_q       <= `PIC_ACK_GAP;
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register access and burst end
  // --------------------------------------------------------------------
  // Forwards register requests; software loads DMA parameters first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= '0;
      bus.reg_wdata <= '0;
      bus.dma_done  <= 1'b0;
      bus.done_dch  <= '0;
    end else begin
      bus.reg_wr    <= wr;
      bus.reg_rd    <= rd;
      bus.reg_addr  <= addr;
      bus.reg_wdata <= wdata;
      bus.dma_done  <= burst_end;
      bus.done_dch  <= burst_dch;
    end
  end

  assign rdata = bus.reg_rdata;
  assign mask  = mask_q;
endmodule
`default_nettype wire

//--- pic_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_props
  import pic_pkg::*;
(
  input wire logic      mclk,      // System clock
  input wire logic      resetn,    // Asynchronous reset, low
  input wire logic      int_req,   // Presented request
  input wire pic_lvl_t  int_level, // Presented level
  input wire pic_vec_t  int_vec,   // Presented vector
  input wire logic      int_dma,   // Presented request is DMA
  input wire pic_dch_t  int_dch,   // Presented DMA channel
  input wire logic      int_ack,   // Vector read by the CPU
  input wire pic_vec_t  ack_vec,   // Vector being read
  input wire logic      dma_done,  // Burst end pulse
  input wire pic_dch_t  done_dch,  // Channel that ended
  input wire logic      reg_wr,    // Register write strobe
  input wire logic      reg_rd,    // Register read strobe
  input wire pic_byte_t reg_addr,  // Register address
  input wire pic_byte_t reg_wdata, // Write data
  input wire pic_byte_t reg_rdata  // Read data
);
  // --------------------------------------------------------------
  // Link properties, one clock domain
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Nothing at level zero reaches the CPU
  property p_no_lvl0;
    int_req |-> int_level != 3'h0;
  endproperty
  a_no_lvl0: assert property (p_no_lvl0)
    else $error("request presented at level zero");

  // Level seven belongs to the watchdog alone
  property p_lvl7_nmi;
    int_req && int_level == 3'h7 |-> int_vec == 6'h3f;
  endproperty
  a_lvl7_nmi: assert property (p_lvl7_nmi)
    else $error("maskable request presented at level seven");

  // Watchdog vector always comes with level seven
  property p_nmi_lvl;
    int_req && int_vec == 6'h3f |-> int_level == 3'h7 && !int_dma;
  endproperty
  a_nmi_lvl: assert property (p_nmi_lvl)
    else $error("watchdog presented below level seven");

  // Routed requests are raised at level six
  property p_dma_lvl;
    int_dma |-> int_req && int_level == 3'h6;
  endproperty
  a_dma_lvl: assert property (p_dma_lvl)
    else $error("DMA request not at level six");

  // A level written is read back right after
  property p_lvl_back;
    reg_wr && reg_addr == 8'h90 ##2 reg_rd && reg_addr == 8'h90
      |=> {reg_rdata[6:4], reg_rdata[2:0]} ==
          {$past(reg_wdata[6:4], 3), $past(reg_wdata[2:0], 3)};
  endproperty
  a_lvl_back: assert property (p_lvl_back)
    else $error("priority level read back differs");

  // A clear write removes the presented vector two edges later
  property p_clr_drop;
    reg_wr && reg_addr == 8'h88 && int_req && !int_dma &&
      reg_wdata[5:0] == int_vec && int_vec != 6'h3f
      |-> ##2 int_vec != $past(reg_wdata[5:0], 2) || !int_req;
  endproperty
  a_clr_drop: assert property (p_clr_drop)
    else $error("cleared request still presented");

  // Burst end drops that DMA channel two edges later
  property p_done_drop;
    dma_done && int_dma && int_dch == done_dch
      |-> ##2 !(int_dma && int_dch == $past(done_dch, 2));
  endproperty
  a_done_drop: assert property (p_done_drop)
    else $error("ended DMA channel still presented");

  // A request stays up while no clearing event occurs
  property p_req_hold;
    (!int_ack && !dma_done && !reg_wr) [*2] ##0 int_req |=> int_req;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped without a clearing event");
endmodule
`default_nettype wire

//--- prioritized_interrupt_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_test;
  import pic_pkg::*;
  logic        mclk, resetn, wdt_req, return_from_interrupt, burst_end, wr, rd;
  logic        irq_taken, dma_taken;  // Accept pulses
  logic [35:0] src_req;               // Peripheral requests
  pic_dch_t    burst_dch, taken_dch;  // DMA channels
  pic_byte_t   addr, wdata, rdata, d; // Register traffic
  pic_lvl_t    mask;                  // CPU mask
  pic_vec_t    taken_vec;             // Accepted vector
  logic        mask_ld;               // Mask load pulse
  pic_lvl_t    mask_new;              // Mask value to load
  int          n_mismatch, comparisons;

  // ------------------------------------------------------------
  // Both ends joined by one link
  // ------------------------------------------------------------
  pic_if pic_if_i ();
  pic_ctrl pic_ctrl_i (.mclk(mclk), .resetn(resetn), .src_req(src_req),
    .wdt_req(wdt_req), .bus(pic_if_i.dev));
  pic_cpu pic_cpu_i (.mclk(mclk), .resetn(resetn), .return_from_interrupt(return_from_interrupt),
    .mask_ld(mask_ld), .mask_new(mask_new),
    .burst_end(burst_end), .burst_dch(burst_dch), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata), .rdata(rdata), .mask(mask),
    .irq_taken(irq_taken), .dma_taken(dma_taken),
    .taken_vec(taken_vec), .taken_dch(taken_dch), .bus(pic_if_i.cpu));
  pic_ctrl_props pic_ctrl_props_i (.mclk(mclk), .resetn(resetn),
    .int_req(pic_if_i.int_req), .int_level(pic_if_i.int_level),
    .int_vec(pic_if_i.int_vec), .int_dma(pic_if_i.int_dma),
    .int_dch(pic_if_i.int_dch), .int_ack(pic_if_i.int_ack),
    .ack_vec(pic_if_i.ack_vec), .dma_done(pic_if_i.dma_done),
    .done_dch(pic_if_i.done_dch), .reg_wr(pic_if_i.reg_wr),
    .reg_rd(pic_if_i.reg_rd), .reg_addr(pic_if_i.reg_addr),
    .reg_wdata(pic_if_i.reg_wdata), .reg_rdata(pic_if_i.reg_rdata));

  // Clock of 20 ns
  always #10 mclk = ~mclk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register write, one strobe, then one idle cycle so that a
  // following write never lowers and raises wr in one step
  task automatic reg_write(input pic_byte_t a, input pic_byte_t v);
    wr = 1'b1; addr = a; wdata = v;
    @(negedge mclk); wr = 1'b0;
    @(negedge mclk);
  endtask
  // Register read, data two edges on
  task automatic reg_read(input pic_byte_t a, output pic_byte_t v);
    rd = 1'b1; addr = a;
    @(negedge mclk); rd = 1'b0;
    @(negedge mclk); v = rdata;
  endtask
  // One request pulse, then settle; 36 is the watchdog
  task automatic pulse(input int ch);
    if (ch < 36) src_req[ch] = 1'b1;
    else wdt_req = 1'b1;
    @(negedge mclk); src_req = '0; wdt_req = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // Burst end on a DMA channel
  task automatic burst(input pic_dch_t c);
    burst_end = 1'b1; burst_dch = c;
    @(negedge mclk); burst_end = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // Return from interrupt, mask checked right after the pop
  task automatic ret_chk(input pic_lvl_t m);
    return_from_interrupt = 1'b1;
    @(negedge mclk); return_from_interrupt = 1'b0;
    chk("mask", m, mask);
    @(negedge mclk);
  endtask
  // Compare what is presented to the CPU
  task automatic present(input logic r, input logic m, input pic_dch_t c,
                         input pic_lvl_t l, input pic_vec_t v);
    chk("presented", {3'h0, r, m, c, l, v}, {3'h0, pic_if_i.int_req,
      pic_if_i.int_dma, pic_if_i.int_dch, pic_if_i.int_level,
      pic_if_i.int_vec});
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0; resetn = 1'b0; src_req = '0; wdt_req = 1'b0;
    return_from_interrupt = 1'b0; burst_end = 1'b0; burst_dch = '0; wr = 1'b0;
    rd = 1'b0; addr = '0; wdata = '0; n_mismatch = 0; comparisons = 0;
    mask_ld = 1'b0; mask_new = '0;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    reg_read(8'h90, d); chk("pri0", 8'h00, d);
    chk("mask", 3'h7, mask);
    reg_write(8'h90, 8'h33); reg_read(8'h90, d);
    chk("pri0", 8'h33, d);
    pulse(1); present(1, 0, 0, 3, 2);
    pulse(0); present(1, 0, 0, 3, 1);
    reg_read(8'h90, d); chk("pri0", 8'hbb, d);
    reg_write(8'h91, 8'h50); pulse(3); present(1, 0, 0, 5, 4);
    reg_write(8'h88, 8'h04); repeat (3) @(negedge mclk);
    present(1, 0, 0, 3, 1);
    reg_read(8'h91, d); chk("pri1", 8'h50, d);
    for (int i = 0; i < 2; i++) begin
      reg_write(8'h92, i ? 8'h07 : 8'h00); pulse(4);
      present(1, 0, 0, 3, 1);
    end
    reg_write(8'h88, 8'h05);
    reg_write(8'h80, 8'h02); reg_write(8'h81, 8'h01);
    repeat (3) @(negedge mclk);
    present(1, 1, 0, 6, 2);
    reg_read(8'h80, d); chk("dvec0", 8'h02, d);
    burst(2'h0); present(1, 1, 1, 6, 1);
    reg_read(8'h80, d); chk("dvec0", 8'h00, d);
    burst(2'h1); chk("int_req", 1'b0, pic_if_i.int_req);
    chk("taken", 2'b00, {irq_taken, dma_taken});
    pulse(3); pulse(36); present(1, 0, 0, 7, 6'h3f);
    chk("mask", 3'h7, mask);
    ret_chk(3'h7);
    // Software opens the mask; the waiting watchdog is taken first
    mask_ld = 1'b1; mask_new = 3'h0;
    @(negedge mclk); mask_ld = 1'b0;
    repeat (4) @(negedge mclk);
    chk("taken_vec", 6'h3f, taken_vec);
    chk("mask", 3'h7, mask);
    present(1, 0, 0, 5, 4);
    ret_chk(3'h0);
    repeat (2) @(negedge mclk);
    chk("mask", 3'h6, mask);
    chk("taken_vec", 6'h04, taken_vec);
    chk("int_req", 1'b0, pic_if_i.int_req);
    // Watchdog nests inside the level-five routine
    pulse(36); chk("mask", 3'h7, mask);
    ret_chk(3'h6);
    ret_chk(3'h0);
    // DMA accept leaves the mask alone and clears the source flag
    reg_write(8'h81, 8'h03); pulse(2);
    chk("taken", {2'h1, 6'h03, 3'h0}, {taken_dch, taken_vec, mask});
    @(negedge mclk);
    chk("int_req", 1'b0, pic_if_i.int_req);
    print_verdict();
  end
endmodule
`default_nettype wire
